// ### hw/pcs_pkg.sv
// package: constants for the 16-bit card socket signalling block
package pcs_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	// ----------------------------------------
	// register offsets (word index on the plain port)
	// ----------------------------------------
	localparam logic [3:0] REG_ADDR   = 4'h0;
	localparam logic [3:0] REG_WDATA  = 4'h1;
	localparam logic [3:0] REG_CMD    = 4'h2;
	localparam logic [3:0] REG_RDATA  = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_IRQ    = 4'h5;
	localparam logic [3:0] REG_MASK   = 4'h6;
	localparam logic [3:0] REG_CARD   = 4'h7;
	// ----------------------------------------
	// command fields
	// ----------------------------------------
	localparam int CMD_KIND_LSB  = 0;
	localparam int CMD_EVEN_BIT  = 2;
	localparam int CMD_ODD_BIT   = 3;
	localparam int CMD_ATTR_BIT  = 4;
	localparam int CMD_IOCARD_BIT = 5;
	localparam logic [1:0] KIND_MEMRD = 2'h0;
	localparam logic [1:0] KIND_MEMWR = 2'h1;
	localparam logic [1:0] KIND_IO_READ_STROBE  = 2'h2;
	localparam logic [1:0] KIND_IO_WRITE_STROBE  = 2'h3;
	// ----------------------------------------
	// interrupt bits
	// ----------------------------------------
	localparam int IRQ_W       = 4;
	localparam int IRQ_DONE    = 0;
	localparam int IRQ_CARDIRQ = 1;
	localparam int IRQ_CARD_STATUS_CHANGE  = 2;
	localparam int IRQ_DETECT  = 3;
	localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;
	// ----------------------------------------
	// battery codes
	// ----------------------------------------
	localparam logic [1:0] BAT_GOOD = 2'h0;
	localparam logic [1:0] BAT_WARN = 2'h1;
	localparam logic [1:0] BAT_FAIL = 2'h2;
	// ----------------------------------------
	// timing: strobe width of one card cycle
	// ----------------------------------------
	localparam int CLK_NS     = 20;
	localparam int STROBE_NS  = 100;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	// ----------------------------------------
	// states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_SETUP  = 4'b0010,
		ST_STROBE = 4'b0100,
		ST_HOLD   = 4'b1000
	} pcs_state_t;
endpackage

// ### hw/pcs_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module pcs_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         nrst,
	// pins and synchronised copy
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] meta;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta    <= '1;
			syncOut <= '1;
		end else begin
			meta    <= pinIn;
			syncOut <= meta;
		end
	end
endmodule
`default_nettype wire

// ### hw/pcs_socket.sv
// 16-bit card socket signalling: access sequencer, card status and type sensing
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - drive 26-bit card address, bit 25 top
// - 16-bit data bus, driven only on writes
// - even and odd byte selects per access
// - space select high common, low attribute/io
// - memory write strobe low during memory write
// - memory read strobe low during memory read
// - io write strobe low during io write
// - io read strobe low during io read
// - wait low stalls cycle completion
// - memory card ready low means busy
// - io card ready is active-low interrupt
// - memory card write-protect reports switch position
// - io card low means 16-bit allowed
// - decode battery good, warning, failed
// - io card battery1 is status change
// - io card battery2 audio to speaker
// - card type from detect and sense
module pcs_socket #(
	parameter int STROBE_CYCLES = pcs_pkg::STROBE_CYC
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	output logic             irq,
	// card address and data
	output logic      [25:0] cardAddr,
	input  wire logic [15:0] cardDataIn,
	output logic      [15:0] cardDataOut,
	output logic             cardDataOe,
	// card strobes, active low
	output logic             evenByteSelect_n,
	output logic             oddByteSelect_n,
	output logic             spaceSelect,
	output logic             memWrite_n,
	output logic             memRead_n,
	output logic             ioWriteStrobe_n,
	output logic             ioReadStrobe_n,
	// card status pins
	input  wire logic        inputAcknowledge_n,
	input  wire logic        wait_n,
	input  wire logic        readyIrq,
	input  wire logic        protectWide,
	input  wire logic        batteryDetect1,
	input  wire logic        batteryDetect2,
	input  wire logic        cardDetect1_n,
	input  wire logic        cardDetect2_n,
	input  wire logic        voltageSense1_n,
	input  wire logic        voltageSense2_n,
	// system audio
	output logic             speakerOutput_n
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [9:0] pinSync;
	pcs_sync #(.W(10)) u_sync (
		.mclk   (mclk),
		.nrst   (nrst),
		.pinIn  ({inputAcknowledge_n, wait_n, readyIrq, protectWide, batteryDetect1,
			batteryDetect2, cardDetect1_n, cardDetect2_n, voltageSense1_n,
			voltageSense2_n}),
		.syncOut(pinSync)
	);
	wire sAck_n   = pinSync[9];
	wire sWait_n  = pinSync[8];
	wire sReady   = pinSync[7];
	wire sProtect = pinSync[6];
	wire sBat1    = pinSync[5];
	wire sBat2    = pinSync[4];
	wire [3:0] sDetect = pinSync[3:0];

	// ----------------------------------------
	// registers and decode
	// ----------------------------------------
	logic [25:0]              addrReg;
	logic [15:0]              wdataReg;
	logic [5:0]               cmdReg;
	logic [15:0]              rdataReg;
	logic [pcs_pkg::IRQ_W-1:0] irqStatus;
	logic [pcs_pkg::IRQ_W-1:0] irqMask;
	logic                     ioCard;
	logic                     ackSeen;
	logic                     prevReady;
	logic                     prevBat1;
	logic [3:0]               prevDetect;
	pcs_pkg::pcs_state_t      state;
	pcs_pkg::pcs_state_t      next_state;
	logic [7:0]               cnt;

	wire wrAddr   = regWr && regAddr == pcs_pkg::REG_ADDR;
	wire wrWdata  = regWr && regAddr == pcs_pkg::REG_WDATA;
	wire wrCmd    = regWr && regAddr == pcs_pkg::REG_CMD;
	wire wrMask   = regWr && regAddr == pcs_pkg::REG_MASK;
	wire rdIrq    = regRd && regAddr == pcs_pkg::REG_IRQ;
	wire idle     = state == pcs_pkg::ST_IDLE;
	wire busy     = !idle;
	// memory card: ready high means it can take a command
	wire memBusy  = !ioCard && !sReady;
	wire startOk  = wrCmd && idle;
	// an accepted command is decoded in its own write cycle, so the pins set up
	// at that edge already carry its selects and data direction, not the last one
	wire [5:0] cmdNext = (startOk && !memBusy) ? regWdata[5:0] : cmdReg;
	wire [1:0] kind = cmdNext[pcs_pkg::CMD_KIND_LSB +: 2];
	wire isWrite  = kind == pcs_pkg::KIND_MEMWR || kind == pcs_pkg::KIND_IO_WRITE_STROBE;
	wire isIo     = kind == pcs_pkg::KIND_IO_READ_STROBE || kind == pcs_pkg::KIND_IO_WRITE_STROBE;

	// io card: ready pin is an active-low interrupt
	wire cardIrqEvt = ioCard && prevReady && !sReady;
	// io card: battery1 is status change, active low
	wire stsChgEvt  = ioCard && prevBat1 && !sBat1;
	wire detectEvt  = sDetect != prevDetect;
	wire strobeEnd  = state == pcs_pkg::ST_STROBE && cnt == 8'h00 && sWait_n;
	wire doneEvt    = state == pcs_pkg::ST_HOLD;
	wire [pcs_pkg::IRQ_W-1:0] events = {detectEvt, stsChgEvt, cardIrqEvt, doneEvt};

	// memory card battery decode: first low fails regardless of second
	wire [1:0] battery = !sBat1 ? pcs_pkg::BAT_FAIL :
		(sBat2 ? pcs_pkg::BAT_GOOD : pcs_pkg::BAT_WARN);
	// memory card switch position; io card wide-access grant
	wire writeProtect = !ioCard && sProtect;
	wire wideIoGrant  = ioCard && !sProtect;
	// card present when both detects low; sense code gives voltage class
	wire cardPresent  = !sDetect[3] && !sDetect[2];
	wire [3:0] cardType = {cardPresent, ioCard, sDetect[1:0]};

	// ----------------------------------------
	// access sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			pcs_pkg::ST_IDLE:   if (wrCmd && !memBusy) next_state = pcs_pkg::ST_SETUP;
			pcs_pkg::ST_SETUP:  next_state = pcs_pkg::ST_STROBE;
			pcs_pkg::ST_STROBE: if (strobeEnd) next_state = pcs_pkg::ST_HOLD;
			pcs_pkg::ST_HOLD:   next_state = pcs_pkg::ST_IDLE;
			default:            next_state = pcs_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= pcs_pkg::ST_IDLE;
			cnt   <= 8'h00;
		end else begin
			state <= next_state;
			if (state == pcs_pkg::ST_SETUP) begin
				cnt <= 8'(STROBE_CYCLES - 1);
			end else if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end
		end
	end

	// commands written while busy are dropped; while a memory card is busy only their io-card bit is taken
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			addrReg  <= 26'h0000000;
			wdataReg <= 16'h0000;
			cmdReg   <= 6'h00;
			irqMask  <= pcs_pkg::MASK_RESET;
			ioCard   <= 1'b0;
		end else begin
			if (wrAddr && idle) addrReg <= regWdata[25:0];
			if (wrWdata && idle) wdataReg <= regWdata[15:0];
			if (startOk && !memBusy) cmdReg <= regWdata[5:0];
			if (startOk) ioCard <= regWdata[pcs_pkg::CMD_IOCARD_BIT];
			if (wrMask) irqMask <= regWdata[pcs_pkg::IRQ_W-1:0];
		end
	end

	// read data and acknowledge capture at end of strobe
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdataReg <= 16'h0000;
			ackSeen  <= 1'b0;
		end else if (strobeEnd) begin
			if (!isWrite) rdataReg <= cardDataIn;
			ackSeen <= kind == pcs_pkg::KIND_IO_READ_STROBE && !sAck_n;
		end
	end

	// sticky status: a set in the read cycle survives the clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irqStatus  <= '0;
			prevReady  <= 1'b1;
			prevBat1   <= 1'b1;
			prevDetect <= 4'hF;
		end else begin
			irqStatus  <= (rdIrq ? '0 : irqStatus) | events;
			prevReady  <= sReady;
			prevBat1   <= sBat1;
			prevDetect <= sDetect;
		end
	end

	// ----------------------------------------
	// card pins, all from flip-flops
	// ----------------------------------------
	// pins register the next state so they change together with the sequencer
	wire inStrobe = next_state == pcs_pkg::ST_STROBE;
	wire inCycle  = next_state != pcs_pkg::ST_IDLE;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cardAddr         <= 26'h0000000;
			cardDataOut      <= 16'h0000;
			cardDataOe       <= 1'b0;
			evenByteSelect_n <= 1'b1;
			oddByteSelect_n  <= 1'b1;
			spaceSelect      <= 1'b1;
			memWrite_n       <= 1'b1;
			memRead_n        <= 1'b1;
			ioWriteStrobe_n  <= 1'b1;
			ioReadStrobe_n   <= 1'b1;
			speakerOutput_n  <= 1'b1;
		end else begin
			cardAddr         <= addrReg;
			cardDataOut      <= wdataReg;
			cardDataOe       <= inCycle && isWrite;
			evenByteSelect_n <= !(inCycle && cmdNext[pcs_pkg::CMD_EVEN_BIT]);
			oddByteSelect_n  <= !(inCycle && cmdNext[pcs_pkg::CMD_ODD_BIT]);
			spaceSelect      <= !(isIo || cmdNext[pcs_pkg::CMD_ATTR_BIT]);
			// kind decodes to one strobe only, none outside the strobe phase
			memWrite_n       <= !(inStrobe && kind == pcs_pkg::KIND_MEMWR);
			memRead_n        <= !(inStrobe && kind == pcs_pkg::KIND_MEMRD);
			ioWriteStrobe_n  <= !(inStrobe && kind == pcs_pkg::KIND_IO_WRITE_STROBE);
			ioReadStrobe_n   <= !(inStrobe && kind == pcs_pkg::KIND_IO_READ_STROBE);
			speakerOutput_n  <= ioCard ? sBat2 : 1'b1;
		end
	end

	// ----------------------------------------
	// register read and interrupt
	// ----------------------------------------
	logic [31:0] rdMux;
	always_comb begin
		case (regAddr)
			pcs_pkg::REG_ADDR:   rdMux = {6'h00, addrReg};
			pcs_pkg::REG_WDATA:  rdMux = {16'h0000, wdataReg};
			pcs_pkg::REG_CMD:    rdMux = {26'h0000000, cmdReg};
			pcs_pkg::REG_RDATA:  rdMux = {16'h0000, rdataReg};
			pcs_pkg::REG_STATUS: rdMux = {22'h000000, wideIoGrant, writeProtect, battery,
				ackSeen, memBusy, !sReady && ioCard, sBat1, sBat2, busy};
			pcs_pkg::REG_IRQ:    rdMux = {28'h0000000, irqStatus};
			pcs_pkg::REG_MASK:   rdMux = {28'h0000000, irqMask};
			pcs_pkg::REG_CARD:   rdMux = {28'h0000000, cardType};
			default:             rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			regRdata <= 32'h00000000;
			irq      <= 1'b0;
		end else begin
			regRdata <= regRd ? rdMux : 32'h00000000;
			irq      <= |(irqStatus & irqMask);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	one_strobe_a: assert property (@(posedge mclk) disable iff (!nrst)
		$countones({~memWrite_n, ~memRead_n, ~ioWriteStrobe_n, ~ioReadStrobe_n}) <= 1)
		else $error("more than one card strobe active");
	idle_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
		$past(idle) && idle |-> memWrite_n && memRead_n && ioWriteStrobe_n && ioReadStrobe_n)
		else $error("strobe active while idle");
	wait_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
		state == pcs_pkg::ST_STROBE && !sWait_n |=> state == pcs_pkg::ST_STROBE)
		else $error("cycle completed during wait");
	mem_write_a: assert property (@(posedge mclk) disable iff (!nrst)
		!memWrite_n |-> cardDataOe)
		else $error("memory write without data drive");
	io_read_a: assert property (@(posedge mclk) disable iff (!nrst)
		!ioReadStrobe_n |-> !cardDataOe && !spaceSelect)
		else $error("io read drives data or selects common space");
	io_write_a: assert property (@(posedge mclk) disable iff (!nrst)
		!ioWriteStrobe_n |-> cardDataOe && !spaceSelect)
		else $error("io write without data or wrong space");
	mem_read_a: assert property (@(posedge mclk) disable iff (!nrst)
		!memRead_n |-> !cardDataOe)
		else $error("memory read drives data");
	busy_block_a: assert property (@(posedge mclk) disable iff (!nrst)
		idle && wrCmd && memBusy |=> idle)
		else $error("access started on busy memory card");
	speaker_a: assert property (@(posedge mclk) disable iff (!nrst)
		ioCard && $stable(ioCard) |=> speakerOutput_n == $past(sBat2))
		else $error("audio not forwarded");
	battery_a: assert property (@(posedge mclk) disable iff (!nrst)
		!sBat1 |-> battery == pcs_pkg::BAT_FAIL)
		else $error("battery fail misdecoded");
	strobe_len_a: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(state == pcs_pkg::ST_STROBE) |-> (state == pcs_pkg::ST_STROBE)[*2])
		else $error("strobe phase too short");
	addr_drive_a: assert property (@(posedge mclk) disable iff (!nrst)
		!evenByteSelect_n || !oddByteSelect_n |-> cardAddr == addrReg)
		else $error("card address differs from programmed address");
	data_drive_a: assert property (@(posedge mclk) disable iff (!nrst)
		cardDataOe |-> cardDataOut == wdataReg)
		else $error("driven data differs from programmed data");
	byte_select_a: assert property (@(posedge mclk) disable iff (!nrst)
		!memWrite_n || !memRead_n || !ioWriteStrobe_n || !ioReadStrobe_n |->
		evenByteSelect_n == !cmdReg[pcs_pkg::CMD_EVEN_BIT] &&
		oddByteSelect_n == !cmdReg[pcs_pkg::CMD_ODD_BIT])
		else $error("byte selects differ from command");
	space_mem_a: assert property (@(posedge mclk) disable iff (!nrst)
		!memWrite_n || !memRead_n |-> spaceSelect == !cmdReg[pcs_pkg::CMD_ATTR_BIT])
		else $error("memory space select wrong");
	hold_release_a: assert property (@(posedge mclk) disable iff (!nrst)
		state == pcs_pkg::ST_HOLD |-> memWrite_n && memRead_n && ioWriteStrobe_n &&
		ioReadStrobe_n)
		else $error("strobe still active in hold phase");
	ready_irq_a: assert property (@(posedge mclk) disable iff (!nrst)
		cardIrqEvt |=> irqStatus[pcs_pkg::IRQ_CARDIRQ])
		else $error("card interrupt not recorded");
	status_change_a: assert property (@(posedge mclk) disable iff (!nrst)
		stsChgEvt |=> irqStatus[pcs_pkg::IRQ_CARD_STATUS_CHANGE])
		else $error("status change not recorded");
	detect_evt_a: assert property (@(posedge mclk) disable iff (!nrst)
		detectEvt |=> irqStatus[pcs_pkg::IRQ_DETECT])
		else $error("detect change not recorded");
	speaker_mem_a: assert property (@(posedge mclk) disable iff (!nrst)
		!$past(ioCard) |-> speakerOutput_n)
		else $error("speaker active for memory card");

	mem_rd_c: cover property (@(posedge mclk) !memRead_n ##[1:20] doneEvt);
	io_wr_c:  cover property (@(posedge mclk) !ioWriteStrobe_n ##[1:20] doneEvt);
	wait_c:   cover property (@(posedge mclk) !sWait_n && state == pcs_pkg::ST_STROBE);
	irq_c:    cover property (@(posedge mclk) cardIrqEvt ##2 irq);
	ack_c:    cover property (@(posedge mclk) strobeEnd && kind == pcs_pkg::KIND_IO_READ_STROBE && !sAck_n);
endmodule
`default_nettype wire

// ### test/pcs_card_model.sv
// card-side model: answers reads, acknowledges io reads, stalls with wait
`timescale 1ns/1ns
`default_nettype none
module pcs_card_model (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// socket side
	input  wire logic [25:0] cardAddr,
	input  wire logic [15:0] cardDataOut,
	input  wire logic        cardDataOe,
	input  wire logic        memWrite_n,
	input  wire logic        memRead_n,
	input  wire logic        ioWriteStrobe_n,
	input  wire logic        ioReadStrobe_n,
	// stall length chosen by the bench
	input  wire logic [3:0]  stallCycles,
	// card answers
	output logic      [15:0] cardDataIn,
	output logic             inputAcknowledge_n,
	output logic             wait_n,
	output logic      [15:0] lastWrite
);
	logic [15:0] lastDrive;
	logic [3:0]  stallLeft;
	logic        prevStrobe;
	wire         anyStrobe = !(memWrite_n && memRead_n && ioWriteStrobe_n && ioReadStrobe_n);
	wire         reading   = !memRead_n || !ioReadStrobe_n;
	// a released bus floats: show the inverse so stale data never passes
	assign cardDataIn = reading ? (cardAddr[15:0] ^ 16'h5A3C) : ~lastDrive;
	assign inputAcknowledge_n = ioReadStrobe_n;
	assign wait_n = (stallLeft == 4'h0);
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lastDrive <= 16'h0000;
			stallLeft <= 4'h0;
			prevStrobe <= 1'b0;
			lastWrite <= 16'h0000;
		end else begin
			prevStrobe <= anyStrobe;
			if (reading)
				lastDrive <= cardAddr[15:0] ^ 16'h5A3C;
			if (anyStrobe && !prevStrobe)
				stallLeft <= stallCycles;
			else if (stallLeft != 4'h0)
				stallLeft <= stallLeft - 4'h1;
			if ((!memWrite_n || !ioWriteStrobe_n) && cardDataOe)
				lastWrite <= cardDataOut;
		end
	end
endmodule
`default_nettype wire

// ### test/test_pcs_socket.sv
// testbench: card accesses, status decoding, interrupts and type sensing
`timescale 1ns/1ns
`default_nettype none
module test_pcs_socket;
	// wait reaches the sequencer through the model flop and two sync flops,
	// so a strobe shorter than four cycles could never be stretched
	localparam int P = pcs_pkg::STROBE_CYC;
	logic        mclk, nrst, regWr, regRd, irq, oe, evenN, oddN, space, spk;
	logic        memWr, memRd, io_write_strobe, io_read_strobe, ack, waitN, ready, prot, bat1, bat2, cd1, cd2, vs1, vs2;
	logic [3:0]  regAddr, stallCycles;
	logic [31:0] regWdata, regRdata, d;
	logic [25:0] cardAddr, seenAddr;
	logic [15:0] dIn, dOut, lastWrite;
	logic        seen, multi, seenEven, seenOdd, seenSpace, seenOe;
	int          cnt[4];
	int          errTotal, comparisons, cycles, i;
	pcs_socket #(.STROBE_CYCLES(P)) dut (.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
		.cardAddr(cardAddr), .cardDataIn(dIn), .cardDataOut(dOut), .cardDataOe(oe),
		.evenByteSelect_n(evenN), .oddByteSelect_n(oddN), .spaceSelect(space),
		.memWrite_n(memWr), .memRead_n(memRd), .ioWriteStrobe_n(io_write_strobe), .ioReadStrobe_n(io_read_strobe),
		.inputAcknowledge_n(ack), .wait_n(waitN), .readyIrq(ready), .protectWide(prot),
		.batteryDetect1(bat1), .batteryDetect2(bat2), .cardDetect1_n(cd1), .cardDetect2_n(cd2),
		.voltageSense1_n(vs1), .voltageSense2_n(vs2), .speakerOutput_n(spk));
	pcs_card_model card (.mclk(mclk), .nrst(nrst), .cardAddr(cardAddr), .cardDataOut(dOut),
		.cardDataOe(oe), .memWrite_n(memWr), .memRead_n(memRd), .ioWriteStrobe_n(io_write_strobe),
		.ioReadStrobe_n(io_read_strobe), .stallCycles(stallCycles), .cardDataIn(dIn),
		.inputAcknowledge_n(ack), .wait_n(waitN), .lastWrite(lastWrite));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// strobe lengths and what the pins showed at the first strobe cycle
	always @(posedge mclk) begin
		cnt[0] += int'(!memRd);
		cnt[1] += int'(!memWr);
		cnt[2] += int'(!io_read_strobe);
		cnt[3] += int'(!io_write_strobe);
		if ($countones({!memRd, !memWr, !io_read_strobe, !io_write_strobe}) > 1)
			multi = 1'b1;
		if (!(memRd && memWr && io_read_strobe && io_write_strobe) && !seen) begin
			seen = 1'b1;
			{seenAddr, seenEven, seenOdd, seenSpace, seenOe} = {cardAddr, evenN, oddN, space, oe};
		end
		cycles++;
		if (cycles == 20000) begin
			errTotal++;
			giveVerdict();
		end
	end
	task automatic giveVerdict;
		$display("mismatches %0d, comparisons %0d", errTotal, comparisons);
		if (errTotal == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errTotal++;
			$display("Error at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic checkBit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			errTotal++;
			$display("Error at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic regWrite(input logic [3:0] a, input logic [31:0] v);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic regRead(input logic [3:0] a, output logic [31:0] v);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		v = regRdata;
		@(posedge mclk);
	endtask
	// two sync flops, the event flop and the irq flop; the fifth edge sees the result
	task automatic settle;
		repeat (5) @(posedge mclk);
	endtask
	task automatic doAccess(input logic [1:0] kind, input logic [3:0] stall);
		logic [25:0] a;
		logic [15:0] w;
		logic [2:0]  s;
		int          n;
		a = 26'($urandom);
		w = 16'($urandom);
		s = 3'($urandom);
		if (s[1:0] == 2'h0)
			s[0] = 1'b1;
		stallCycles <= stall;
		regWrite(pcs_pkg::REG_ADDR, {6'h00, a});
		regWrite(pcs_pkg::REG_WDATA, {16'h0000, w});
		cnt = '{default: 0};
		{seen, multi} = 2'b00;
		regWrite(pcs_pkg::REG_CMD, {26'h0, kind[1], s, kind});
		n = 0;
		do begin
			regRead(pcs_pkg::REG_STATUS, d);
			n++;
		end while (d[0] !== 1'b0 && n < 40);
		checkBit(d[0], 1'b0);
		if (stall == 4'h0)
			checkWord(32'(cnt[kind]), 32'(P));
		else
			checkBit(cnt[kind] >= int'(stall), 1'b1);
		checkWord(32'(cnt[0] + cnt[1] + cnt[2] + cnt[3] - cnt[kind]), 32'h0);
		checkBit(multi, 1'b0);
		checkWord({6'h00, seenAddr}, {6'h00, a});
		checkWord({30'h0, seenEven, seenOdd}, {30'h0, ~s[0], ~s[1]});
		checkBit(seenSpace, ~(s[2] | kind[1]));
		checkBit(seenOe, kind[0]);
		if (kind[0])
			checkWord({16'h0, lastWrite}, {16'h0, w});
		else begin
			regRead(pcs_pkg::REG_RDATA, d);
			checkWord({16'h0, d[15:0]}, {16'h0, a[15:0] ^ 16'h5A3C});
		end
		if (kind == pcs_pkg::KIND_IO_READ_STROBE) begin
			regRead(pcs_pkg::REG_STATUS, d);
			checkBit(d[5], 1'b1);
		end
	endtask
	initial begin
		{nrst, regWr, regRd, regAddr, regWdata, stallCycles} = '0;
		{ready, prot, bat1, bat2, cd1, cd2, vs1, vs2} = 8'hF3;
		{errTotal, comparisons, cycles} = '0;
		void'($urandom(7992));
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		checkWord({28'h0, memRd, memWr, io_read_strobe, io_write_strobe}, 32'hF);
		checkBit(space, 1'b1);
		regRead(pcs_pkg::REG_MASK, d);
		checkWord(d, {28'h0, pcs_pkg::MASK_RESET});
		regRead(4'hF, d);
		checkWord(d, 32'h0);
		for (i = 0; i < 12; i++)
			doAccess(2'(i), (i >= 8) ? 4'h6 : 4'h0);
		doAccess(pcs_pkg::KIND_MEMRD, 4'h0);
		ready <= 1'b0;
		settle();
		cnt = '{default: 0};
		regWrite(pcs_pkg::REG_CMD, 32'h4);
		repeat (10) @(posedge mclk);
		regRead(pcs_pkg::REG_STATUS, d);
		checkWord({30'h0, d[4], d[0]}, 32'h2);
		checkWord(32'(cnt[0]), 32'h0);
		ready <= 1'b1;
		for (i = 0; i < 4; i++) begin
			{bat1, bat2, prot} <= {2'(i), 1'($urandom)};
			settle();
			regRead(pcs_pkg::REG_STATUS, d);
			checkWord({30'h0, d[7:6]}, {30'h0, !bat1 ? pcs_pkg::BAT_FAIL :
				(bat2 ? pcs_pkg::BAT_GOOD : pcs_pkg::BAT_WARN)});
			checkBit(d[8], prot);
		end
		checkBit(spk, 1'b1);
		doAccess(pcs_pkg::KIND_IO_READ_STROBE, 4'h0);
		regRead(pcs_pkg::REG_IRQ, d);
		regWrite(pcs_pkg::REG_MASK, 32'h6);
		ready <= 1'b0;
		settle();
		checkBit(irq, 1'b1);
		regRead(pcs_pkg::REG_IRQ, d);
		checkWord(d, 32'h2);
		settle();
		checkBit(irq, 1'b0);
		{ready, bat1} <= 2'b10;
		settle();
		checkBit(irq, 1'b1);
		regRead(pcs_pkg::REG_IRQ, d);
		checkWord(d, 32'h4);
		regWrite(pcs_pkg::REG_MASK, 32'h8);
		{bat1, ready} <= 2'b10;
		settle();
		checkBit(irq, 1'b0);
		regRead(pcs_pkg::REG_IRQ, d);
		checkWord(d, 32'h2);
		for (i = 0; i < 4; i++) begin
			{bat2, prot} <= 2'($urandom);
			settle();
			checkBit(spk, bat2);
			regRead(pcs_pkg::REG_STATUS, d);
			checkBit(d[9], ~prot);
		end
		for (i = 0; i < 6; i++) begin
			{cd1, cd2, vs1, vs2} <= (i == 0) ? 4'h8 : 4'($urandom);
			settle();
			if (i == 0)
				checkBit(irq, 1'b1);
			regRead(pcs_pkg::REG_CARD, d);
			checkWord({28'h0, d[3:0]}, {28'h0, !cd1 && !cd2, 1'b1, vs1, vs2});
		end
		giveVerdict();
	end
endmodule
`default_nettype wire
